// File: hw/gain_curve_regs.sv
/*
 * Profile 3 curve registers and gain start / mode control words,
 * decoded for the gain-curve generator.
 * Assumes a classic Wishbone master and the generator on clk.
 */
`default_nettype none
module gain_curve_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [9:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [1:0] profile_select_pins,
    output logic [1:0] active_profile,
    output gain_curve_pkg::curve_mode_t curve_mode,
    output logic [3:0] slope_factor,
    output logic int_start_en,
    output logic manual_start_pulse,
    output logic [1:0] mem_bank,
    output logic [8:0] fixed_gain_code,
    output logic [3:0] input_resistor_select,
    output logic atten_first,
    output logic attenuator_en,
    output logic p3_params_valid,
    output gain_curve_pkg::profile_params_t p3_params
);
    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [15:0] step_pair_r;
    logic [15:0] index_pair_r;
    logic [15:0] start_time_r;
    logic [15:0] hold_time_r;
    gain_curve_pkg::start_ctrl_t start_ctrl_r;
    gain_curve_pkg::mode_ctrl_t mode_ctrl_r;
    logic [1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_stable_r;
    logic [1:0] active_profile_nxt;
    logic [7:0] idx;
    logic req, wr;
    logic [15:0] wmask;

    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [15:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    assign idx = wb_adr_i[9:2];
    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr = req && wb_we_i;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // ------------------------------------------------------------
    // Bus answer: one wait state, unmapped reads zero
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= req;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            case (idx)
                gain_curve_pkg::IDX_STEP_PAIR: wb_dat_o <= {16'h0000, step_pair_r};
                gain_curve_pkg::IDX_INDEX_PAIR: wb_dat_o <= {16'h0000, index_pair_r};
                gain_curve_pkg::IDX_START_TIME: wb_dat_o <= {16'h0000, start_time_r};
                gain_curve_pkg::IDX_HOLD_TIME: wb_dat_o <= {16'h0000, hold_time_r};
                gain_curve_pkg::IDX_START_CTRL: wb_dat_o <= {16'h0000, start_ctrl_r};
                gain_curve_pkg::IDX_MODE_CTRL: wb_dat_o <= {16'h0000, mode_ctrl_r};
                gain_curve_pkg::IDX_STATUS: wb_dat_o <= {30'h0000_0000, active_profile};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Profile 3 parameter registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            step_pair_r <= gain_curve_pkg::RST_STEP_PAIR;
            index_pair_r <= gain_curve_pkg::RST_INDEX_PAIR;
            start_time_r <= gain_curve_pkg::RST_TIME;
            hold_time_r <= gain_curve_pkg::RST_TIME;
        end else if (wr) begin
            if (idx == gain_curve_pkg::IDX_STEP_PAIR) begin
                step_pair_r <= merge(step_pair_r, wb_dat_i[15:0], wmask);
            end
            if (idx == gain_curve_pkg::IDX_INDEX_PAIR) begin
                index_pair_r <= merge(index_pair_r, wb_dat_i[15:0], wmask);
            end
            if (idx == gain_curve_pkg::IDX_START_TIME) begin
                start_time_r <= merge(start_time_r, wb_dat_i[15:0], wmask);
            end
            if (idx == gain_curve_pkg::IDX_HOLD_TIME) begin
                hold_time_r <= merge(hold_time_r, wb_dat_i[15:0], wmask);
            end
        end
    end

    // ------------------------------------------------------------
    // Control words; reserved bits stored without effect
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            start_ctrl_r <= gain_curve_pkg::RST_CTRL;
            mode_ctrl_r <= gain_curve_pkg::RST_CTRL;
        end else if (wr) begin
            if (idx == gain_curve_pkg::IDX_START_CTRL) begin
                start_ctrl_r <= merge(start_ctrl_r, wb_dat_i[15:0], wmask);
            end
            if (idx == gain_curve_pkg::IDX_MODE_CTRL) begin
                mode_ctrl_r <= merge(mode_ctrl_r, wb_dat_i[15:0], wmask);
            end
        end
    end

    // One-shot start on a write of 1 to the manual start bit
    always_ff @(posedge clk) begin
        if (rst) begin
            manual_start_pulse <= 1'b0;
        end else begin
            manual_start_pulse <= wr && idx == gain_curve_pkg::IDX_START_CTRL &&
                wb_sel_i[1] && wb_dat_i[gain_curve_pkg::SC_MANUAL_START];
        end
    end

    // ------------------------------------------------------------
    // Profile pins: three-stage sync, change when stages 2 and 3 agree
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
            pin_s3_r <= 2'h0;
            pin_stable_r <= 2'h0;
        end else begin
            pin_s1_r <= profile_select_pins;
            pin_s2_r <= pin_s1_r;
            pin_s3_r <= pin_s2_r;
            if (pin_s2_r == pin_s3_r) begin
                pin_stable_r <= pin_s3_r;
            end
        end
    end

    always_comb begin
        if (mode_ctrl_r.pin_profile_override) begin
            active_profile_nxt = mode_ctrl_r.profile_reg;
        end else begin
            active_profile_nxt = pin_stable_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            active_profile <= 2'h0;
        end else begin
            active_profile <= active_profile_nxt;
        end
    end

    // ------------------------------------------------------------
    // Decoded outputs toward the gain-curve generator
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            curve_mode <= gain_curve_pkg::MODE_EXT_NONUNIFORM;
            slope_factor <= 4'h0;
            int_start_en <= 1'b0;
            mem_bank <= 2'h0;
            fixed_gain_code <= 9'h000;
            input_resistor_select <= 4'h0;
            atten_first <= 1'b1;
            attenuator_en <= 1'b1;
        end else begin
            curve_mode <= gain_curve_pkg::curve_mode_t'(mode_ctrl_r.mode);
            slope_factor <= {mode_ctrl_r.slope_factor_upper,
                             start_ctrl_r.slope_factor_lsb};
            int_start_en <= start_ctrl_r.int_start_en;
            mem_bank <= start_ctrl_r.mem_bank;
            fixed_gain_code <= start_ctrl_r.fixed_gain_code;
            input_resistor_select <= mode_ctrl_r.input_resistor_select;
            atten_first <= !mode_ctrl_r.attenuator_order_swap;
            attenuator_en <= !mode_ctrl_r.attenuator_off;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            p3_params_valid <= 1'b0;
            p3_params <= '0;
        end else if (active_profile_nxt == gain_curve_pkg::PROFILE_3) begin
            p3_params_valid <= 1'b1;
            p3_params <= {step_pair_r, index_pair_r, start_time_r, hold_time_r};
        end else begin
            p3_params_valid <= 1'b0;
            p3_params <= '0;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_step_reset: assert property (@(posedge clk) $fell(rst) |->
        step_pair_r == 16'h00FF && index_pair_r == 16'h009F)
        else $error("step or index reset value wrong");
    a_times_reset: assert property (@(posedge clk) $fell(rst) |->
        start_time_r == 16'h0000 && hold_time_r == 16'h0000)
        else $error("time reset value wrong");
    a_step_write: assert property (@(posedge clk) disable iff (rst)
        wr && idx == 8'hB1 && wb_sel_i == 4'h3 |=> step_pair_r == $past(wb_dat_i[15:0]))
        else $error("step register write lost");
    a_index_write: assert property (@(posedge clk) disable iff (rst)
        wr && idx == gain_curve_pkg::IDX_INDEX_PAIR && wb_sel_i[1:0] == 2'h3 |=>
        index_pair_r == $past(wb_dat_i[15:0]))
        else $error("index register write lost");
    a_hold_write: assert property (@(posedge clk) disable iff (rst)
        wr && idx == 8'hB4 && wb_sel_i[1:0] == 2'h3 |=> hold_time_r == $past(wb_dat_i[15:0]))
        else $error("hold time write lost");
    a_slope_join: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> slope_factor == {$past(mode_ctrl_r[4:2]), $past(start_ctrl_r[15])})
        else $error("slope factor assembly wrong");
    a_start_copy: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> int_start_en == $past(start_ctrl_r[14]) &&
        mem_bank == $past(start_ctrl_r[13:12]) &&
        fixed_gain_code == $past(start_ctrl_r[8:0]))
        else $error("start control copy wrong");
    a_manual_pulse: assert property (@(posedge clk) disable iff (rst)
        manual_start_pulse |=> !manual_start_pulse)
        else $error("manual start longer than one cycle");
    a_manual_cause: assert property (@(posedge clk) disable iff (rst)
        wr && idx == 8'hB5 && wb_sel_i[1] |=> manual_start_pulse == $past(wb_dat_i[10]))
        else $error("manual start not from write");
    a_mode_copy: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> curve_mode == $past(mode_ctrl_r[15:14]))
        else $error("curve mode not from mode word");
    a_profile_choice: assert property (@(posedge clk) disable iff (rst)
        mode_ctrl_r[11] |=> active_profile == $past(mode_ctrl_r[13:12]))
        else $error("register profile select ignored");
    a_pin_profile: assert property (@(posedge clk) disable iff (rst)
        !mode_ctrl_r[11] |=> active_profile == $past(pin_stable_r))
        else $error("pin profile select ignored");
    a_p3_gate: assert property (@(posedge clk) disable iff (rst)
        active_profile != 2'h3 |-> !p3_params_valid && p3_params == '0)
        else $error("profile 3 parameters leak");
    a_order_swap: assert property (@(posedge clk) disable iff (rst)
        1'b1 |=> atten_first == !$past(mode_ctrl_r[6]))
        else $error("attenuator order wrong");
    a_atten_off: assert property (@(posedge clk) disable iff (rst)
        $rose(mode_ctrl_r[5]) |=> !attenuator_en)
        else $error("attenuator not disabled");
    a_ack_once: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule
`default_nettype wire

// File: hw/gain_curve_pkg.sv
/*
 * Register map, field layout and reset values for the profile 3 curve
 * registers and the gain start and mode control words.
 * Assumes a classic Wishbone master with 32-bit data on the same clock.
 */
// Notes on behaviour
// - Step register upper byte holds rising gain step, reset zero.
// - Step register lower byte holds falling gain step, reset FF.
// - Index register upper byte holds start index, reset zero.
// - Index register lower byte holds stop index, reset 9F.
// - Sixteen-bit start gain time register, reset zero.
// - Sixteen-bit hold gain time register, reset zero.
// - Slope factor lsb at control bit 15, upper three at mode bits 4-2.
// - Internal start enable: 0 external start, 1 periodic internal start.
// - Two-bit memory bank select, default bank zero.
// - Writing 1 to manual start gives one start pulse; 0 does nothing.
// - Nine-bit fixed gain code for fixed-gain mode, reset zero.
// - Mode word layout: mode, profile, override, resistor, swap, off, slope.
// - Mode 00 external, 01 ramp, 10 fixed gain, 11 internal non-uniform.
// - Override 0 uses profile pins; 1 uses profile register field.
// - Swap 0 attenuation first; 1 amplifier gain first.
// - Attenuator off bit 0 enables, 1 disables attenuator.
`default_nettype none
package gain_curve_pkg;
    // ------------------------------------------------------------
    // Register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_STEP_PAIR = 8'hB1;
    localparam logic [7:0] IDX_INDEX_PAIR = 8'hB2;
    localparam logic [7:0] IDX_START_TIME = 8'hB3;
    localparam logic [7:0] IDX_HOLD_TIME = 8'hB4;
    localparam logic [7:0] IDX_START_CTRL = 8'hB5;
    localparam logic [7:0] IDX_MODE_CTRL = 8'hB6;
    localparam logic [7:0] IDX_STATUS = 8'hB8;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_STEP_PAIR = 16'h00FF;
    localparam logic [15:0] RST_INDEX_PAIR = 16'h009F;
    localparam logic [15:0] RST_TIME = 16'h0000;
    localparam logic [15:0] RST_CTRL = 16'h0000;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SC_SLOPE_LSB = 15;
    localparam int SC_INT_START = 14;
    localparam int SC_MANUAL_START = 10;
    localparam logic [1:0] PROFILE_3 = 2'h3;

    typedef enum logic [1:0] {
        MODE_EXT_NONUNIFORM,
        MODE_RAMP,
        MODE_FIXED_GAIN,
        MODE_INT_NONUNIFORM
    } curve_mode_t;

    typedef struct packed {
        logic [1:0] mode;
        logic [1:0] profile_reg;
        logic pin_profile_override;
        logic [3:0] input_resistor_select;
        logic attenuator_order_swap;
        logic attenuator_off;
        logic [2:0] slope_factor_upper;
        logic [1:0] reserved;
    } mode_ctrl_t;

    typedef struct packed {
        logic slope_factor_lsb;
        logic int_start_en;
        logic [1:0] mem_bank;
        logic reserved_hi;
        logic manual_start;
        logic reserved_lo;
        logic [8:0] fixed_gain_code;
    } start_ctrl_t;

    typedef struct packed {
        logic [7:0] rise_step;
        logic [7:0] fall_step;
        logic [7:0] start_index;
        logic [7:0] stop_index;
        logic [15:0] start_time;
        logic [15:0] hold_time;
    } profile_params_t;
endpackage
`default_nettype wire

// File: tb/tb_top.sv
/*
 * Self-checking bench for the profile 3 curve registers and control words.
 * Assumes gain_curve_regs and gain_curve_pkg compiled first; Wishbone on clk.
 */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [9:0] wb_adr_i = 10'h000;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h00000000;
    logic [1:0] profile_select_pins = 2'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [1:0] active_profile;
    gain_curve_pkg::curve_mode_t curve_mode;
    logic [3:0] slope_factor;
    logic int_start_en;
    logic manual_start_pulse;
    logic [1:0] mem_bank;
    logic [8:0] fixed_gain_code;
    logic [3:0] input_resistor_select;
    logic atten_first;
    logic attenuator_en;
    logic p3_params_valid;
    gain_curve_pkg::profile_params_t p3_params;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;
    int pulses = 0;
    logic [31:0] rd;
    // Rows: index, write data, expected read
    logic [39:0] rows [8] = '{
        {8'hB1, 16'h1234, 16'h1234}, {8'hB2, 16'h5678, 16'h5678},
        {8'hB3, 16'h9ABC, 16'h9ABC}, {8'hB4, 16'hDEF0, 16'hDEF0},
        {8'hB7, 16'h5555, 16'h0000}, {8'hB8, 16'hFFFF, 16'h0000},
        {8'hB5, 16'hF5FF, 16'hF5FF}, {8'hB6, 16'hFFFC, 16'hFFFC}};

    gain_curve_regs i_gain_curve_regs (
        .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .profile_select_pins(profile_select_pins),
        .active_profile(active_profile), .curve_mode(curve_mode),
        .slope_factor(slope_factor), .int_start_en(int_start_en),
        .manual_start_pulse(manual_start_pulse), .mem_bank(mem_bank),
        .fixed_gain_code(fixed_gain_code), .input_resistor_select(input_resistor_select),
        .atten_first(atten_first), .attenuator_en(attenuator_en),
        .p3_params_valid(p3_params_valid), .p3_params(p3_params));

    // ------------------------------------------------------------
    // Clock, pulse count and hang guard
    // ------------------------------------------------------------
    always #25 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (manual_start_pulse === 1'b1) begin
            pulses++;
        end
        if (cycles == 5000) begin
            mismatches++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Classic cycle, held until ack is sampled high
    task automatic bus(input logic w, input logic [7:0] idx, input logic [3:0] s,
                       input logic [15:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {idx, 2'h0};
        wb_sel_i <= s;
        wb_dat_i <= {16'h0000, d};
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    task automatic rd_check(input logic [7:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 4'h3, 16'h0000);
        check(rd, {16'h0000, exp});
    endtask

    task automatic settle();
        repeat (8) @(posedge clk);
    endtask

    task automatic check_resets();
        rd_check(8'hB1, 16'h00FF);
        rd_check(8'hB2, 16'h009F);
        rd_check(8'hB3, 16'h0000);
        rd_check(8'hB4, 16'h0000);
        rd_check(8'hB5, 16'h0000);
        rd_check(8'hB6, 16'h0000);
        check(atten_first, 1'b1);
        check(attenuator_en, 1'b1);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        check_resets();
        for (int i = 0; i < 8; i++) begin
            bus(1'b1, rows[i][39:32], 4'h3, rows[i][31:16]);
            rd_check(rows[i][39:32], rows[i][15:0]);
        end
        settle();
        check(slope_factor, 4'hF);
        check(int_start_en, 1'b1);
        check(mem_bank, 2'h3);
        check(fixed_gain_code, 9'h1FF);
        check(input_resistor_select, 4'hF);
        check(atten_first, 1'b0);
        check(attenuator_en, 1'b0);
        check(active_profile, 2'h3);
        check(p3_params_valid, 1'b1);
        check(p3_params, 64'h123456789ABCDEF0);
        check(pulses, 1);
        bus(1'b1, 8'hB5, 4'h3, 16'hF1FF);
        bus(1'b1, 8'hB5, 4'h3, 16'hF5FF);
        settle();
        check(pulses, 2);
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 8'hB6, 4'h3, {m[1:0], 14'h0000});
            settle();
            check(curve_mode, m);
        end
        // Pins decide the profile once the override is clear
        profile_select_pins <= 2'h1;
        settle();
        check(active_profile, 2'h1);
        check(p3_params_valid, 1'b0);
        check(p3_params, 64'h0);
        profile_select_pins <= 2'h3;
        settle();
        check(p3_params, 64'h123456789ABCDEF0);
        bus(1'b1, 8'hB3, 4'h0, 16'hFFFF);
        bus(1'b1, 8'hB3, 4'h1, 16'h0011);
        rd_check(8'hB3, 16'h9A11);
        // Second reset in mid-run
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        check_resets();
        stop_test();
    end
endmodule
`default_nettype wire
